// ### logic/fxp_rx_pcs.sv
// Receive coding, link monitor and fiber far-end fault for 100 Mb/s
`include "fxp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] Fix the 5-bit boundary only after the pair 11000 10001 is seen.
// [R2] Translate each aligned 5B code-group to its 4B nibble through a table.
// [R3] Delimiter pair after idles is replaced by two preamble nibbles 0101.
// [R4] Stop conversion on the end delimiter pair or two consecutive idles.
// [R5] Link up and coding enabled only after signal detect holds 395 us.
// [R6] Idle to non-idle change without the delimiter pair is a bad start.
// [R7] Bad start drives error high and nibble 1110 until two idles arrive.
// [R8] Each bad start adds exactly one to the false carrier counter.
// [R9] Error and carrier drop once two idles follow a bad start.
// [R10] Fiber mode comes from a strap caught at reset or a config write.
// [R11] Fiber transmit skips scrambling and three-level coding, sends NRZI.
// [R12] Fiber receive skips three-level decoding and descrambling.
// [R13] Fiber mode without received signal sends the far-end fault pattern.
// [R14] Fault pattern is three or more cycles of 84 ones then one zero.
// [R15] Fiber receive watches for the fault pattern and forces link down.
// [R16] While forced down by a far-end fault, transmit only idles.
// [R17] An idle code-group is five ones, 11111.
// [R18] Aligner drops its boundary and hunts again after reception ends.
// [R19] Fault is declared after three consecutive 84-ones-one-zero cycles.
module fxp_rx_pcs
  import fxp_pkg::*;
#(
  parameter int LINK_CYC = `FXP_LINK_CYC
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      ce,
  // Fiber mode configuration
  input  wire logic      fx_strap,
  input  wire logic      fx_cfg_we,
  input  wire logic      fx_cfg_val,
  // Receive line side
  input  wire logic      sig_det,
  input  wire logic      rx_line_nrzi,
  input  wire logic      rx_descr_bit,
  // Transmit sources
  input  wire logic      tx_nrz_bit,
  input  wire logic      tx_scr_bit,
  // Transmit line side
  output logic           tx_line_nrzi,
  output logic           tx_mlt3_en,
  // Status
  output logic           fiber_mode,
  output logic           link_up,
  output logic           fef_seen,
  output logic [15:0]    false_carrier_cnt,
  // MII receive
  output fxp_mii_s       mii_rx,
  output logic           rx_nib_stb
);

  // 5B to 4B table; anything outside the data set is flagged
  function automatic fxp_dec_s cg_decode(input logic [4:0] cg);
    fxp_dec_s r;
    r.err = 1'b0;
    r.nib = `FXP_NIB_ZERO;
    case (cg)
      5'h1E: r.nib = 4'h0;
      5'h09: r.nib = 4'h1;
      5'h14: r.nib = 4'h2;
      5'h15: r.nib = 4'h3;
      5'h0A: r.nib = 4'h4;
      5'h0B: r.nib = 4'h5;
      5'h0E: r.nib = 4'h6;
      5'h0F: r.nib = 4'h7;
      5'h12: r.nib = 4'h8;
      5'h13: r.nib = 4'h9;
      5'h16: r.nib = 4'hA;
      5'h17: r.nib = 4'hB;
      5'h1A: r.nib = 4'hC;
      5'h1B: r.nib = 4'hD;
      5'h1C: r.nib = 4'hE;
      5'h1D: r.nib = 4'hF;
      default: r.err = 1'b1;
    endcase
    return r;
  endfunction : cg_decode

  function automatic logic cg_is_idle(input logic [4:0] cg);
    return (cg == `FXP_CG_IDLE); // R17
  endfunction : cg_is_idle

  localparam logic [12:0] LINK_LAST = 13'(LINK_CYC - 1);

  // Mode and link state
  logic        strap_pend_r;
  logic        fiber_r;
  logic [12:0] sd_cnt_r;
  logic        sd_ok_r;
  logic        link_r;
  logic        fef_seen_r;

  // Transmit state
  logic        tx_line_r;
  logic        mlt3_en_r;

  // Receive state
  logic        rx_prev_r;
  logic [9:0]  sh_r;
  logic [3:0]  idle_run_r;
  fxp_aln_e    st_r;
  logic [2:0]  tail_r;
  logic [2:0]  ph_r;
  logic        prev_idle_r;
  logic        t_seen_r;
  fxp_dec_s    hold_r;
  fxp_mii_s    mii_r;
  logic        stb_r;
  logic [15:0] fcc_r;

  // Submodule links
  logic        fef_found;
  logic        fef_act;
  logic        fef_bit;

  // Receive bit selection
  wire rx_fiber_nrz = rx_line_nrzi ^ rx_prev_r;
  wire rx_bit       = fiber_r ? rx_fiber_nrz : rx_descr_bit; // R12

  // Alignment decode
  wire [9:0] sh_nxt    = {sh_r[8:0], rx_bit};
  wire [4:0] sym       = sh_nxt[4:0];
  wire       jk_hit    = (sh_nxt == `FXP_JK_PAIR); // R1
  wire       idle_ok   = (idle_run_r == `FXP_IDLE2_RUN);
  wire       ssd_start = idle_ok & ~rx_bit;
  wire       tail_end  = (tail_r == `FXP_JK_TAIL);
  wire       sym_stb   = (ph_r == `FXP_SYM_LAST);
  wire       sym_idle  = cg_is_idle(sym);
  wire       two_idle  = sym_idle & prev_idle_r; // R4
  wire       esd_hit   = t_seen_r & (sym == `FXP_CG_R); // R4
  wire       is_t      = (sym == `FXP_CG_T);
  wire       data_end  = two_idle | esd_hit;

  // Link and fault decode
  wire fef_force = fiber_r & fef_found; // R15
  wire link_nxt  = sd_ok_r & ~fef_force; // R5
  wire fef_req   = fiber_r & ~sig_det; // R13

  // Transmit bit before NRZI: fault pattern, idle, or data
  wire tx_data_bit = fiber_r ? tx_nrz_bit : tx_scr_bit; // R11
  wire tx_sel_bit  = fef_act ? fef_bit : (link_r ? tx_data_bit : 1'b1); // R16

  assign tx_line_nrzi      = tx_line_r;
  assign tx_mlt3_en        = mlt3_en_r;
  assign fiber_mode        = fiber_r;
  assign link_up           = link_r;
  assign fef_seen          = fef_seen_r;
  assign false_carrier_cnt = fcc_r;
  assign mii_rx            = mii_r;
  assign rx_nib_stb        = stb_r;

  fxp_fef_gen u_fef_gen (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .req     (fef_req),
    .active  (fef_act),
    .bit_out (fef_bit)
  ); // R14

  fxp_fef_det u_fef_det (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .en     (fiber_r),
    .bit_in (rx_bit),
    .found  (fef_found)
  ); // R19

  // Fiber mode: strap caught on the first enabled edge after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_pend_r <= 1'b1;
      fiber_r      <= 1'b0;
      mlt3_en_r    <= 1'b1;
    end else if (ce) begin
      strap_pend_r <= 1'b0;
      if (strap_pend_r) begin
        fiber_r   <= fx_strap; // R10
        mlt3_en_r <= ~fx_strap; // R11
      end else if (fx_cfg_we) begin
        fiber_r   <= fx_cfg_val; // R10
        mlt3_en_r <= ~fx_cfg_val; // R11
      end
    end
  end

  // Link monitor: signal detect must hold for the full qualification time
  always_ff @(posedge clk) begin
    if (rst) begin
      sd_cnt_r   <= 13'h0000;
      sd_ok_r    <= 1'b0;
      link_r     <= 1'b0;
      fef_seen_r <= 1'b0;
    end else if (ce) begin
      if (!sig_det) begin
        sd_cnt_r <= 13'h0000;
        sd_ok_r  <= 1'b0;
      end else if (sd_cnt_r == LINK_LAST) begin
        sd_ok_r <= 1'b1; // R5
      end else begin
        sd_cnt_r <= sd_cnt_r + 13'h0001;
      end
      link_r     <= link_nxt;
      fef_seen_r <= fef_force;
    end
  end

  // Transmit NRZI encoder
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_line_r <= 1'b0;
    end else if (ce) begin
      tx_line_r <= tx_line_r ^ tx_sel_bit;
    end
  end

  // Receive shifter and idle run tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_prev_r  <= 1'b0;
      sh_r       <= 10'h000;
      idle_run_r <= 4'h0;
    end else if (ce) begin
      rx_prev_r <= rx_line_nrzi;
      sh_r      <= sh_nxt;
      if (!rx_bit) begin
        idle_run_r <= 4'h0;
      end else if (!idle_ok) begin
        idle_run_r <= idle_run_r + 4'h1;
      end
    end
  end

  // Aligner, decoder and MII output
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r        <= FXP_HUNT;
      tail_r      <= 3'h0;
      ph_r        <= 3'h0;
      prev_idle_r <= 1'b0;
      t_seen_r    <= 1'b0;
      hold_r      <= '0;
      mii_r       <= '0;
      stb_r       <= 1'b0;
      fcc_r       <= 16'h0000;
    end else if (ce) begin
      stb_r <= 1'b0;
      if (!link_r) begin
        st_r  <= FXP_HUNT;
        mii_r <= '0;
      end else begin
        case (st_r)
          FXP_HUNT: begin
            ph_r        <= 3'h0;
            prev_idle_r <= 1'b0;
            t_seen_r    <= 1'b0;
            if (ssd_start) begin
              st_r   <= FXP_SSD;
              tail_r <= 3'h0;
            end else if (jk_hit) begin
              st_r        <= FXP_DATA; // R1
              hold_r.err  <= 1'b0;
              hold_r.nib  <= `FXP_NIB_PRE; // R3
              mii_r.crs   <= 1'b1;
              mii_r.dv    <= 1'b1;
              mii_r.er    <= 1'b0;
              mii_r.d     <= `FXP_NIB_PRE; // R3
              stb_r       <= 1'b1;
            end
          end
          FXP_SSD: begin
            tail_r <= tail_r + 3'h1;
            if (tail_end) begin
              mii_r.crs <= 1'b1;
              stb_r     <= 1'b1;
              if (jk_hit) begin
                st_r       <= FXP_DATA; // R1
                hold_r.err <= 1'b0;
                hold_r.nib <= `FXP_NIB_PRE; // R3
                mii_r.dv   <= 1'b1;
                mii_r.er   <= 1'b0;
                mii_r.d    <= `FXP_NIB_PRE; // R3
              end else begin
                st_r     <= FXP_BAD; // R6
                mii_r.dv <= 1'b0;
                mii_r.er <= 1'b1; // R7
                mii_r.d  <= `FXP_NIB_BAD; // R7
                fcc_r    <= fcc_r + 16'h0001; // R8
              end
            end
          end
          FXP_DATA: begin
            ph_r <= sym_stb ? 3'h0 : ph_r + 3'h1;
            if (sym_stb) begin
              prev_idle_r <= sym_idle;
              if (data_end) begin
                st_r  <= FXP_HUNT; // R18
                mii_r <= '0; // R4
              end else begin
                mii_r.dv <= 1'b1;
                mii_r.er <= hold_r.err;
                mii_r.d  <= hold_r.nib;
                stb_r    <= 1'b1;
                hold_r   <= cg_decode(sym); // R2
                t_seen_r <= is_t;
              end
            end
          end
          FXP_BAD: begin
            ph_r <= sym_stb ? 3'h0 : ph_r + 3'h1;
            if (sym_stb) begin
              prev_idle_r <= sym_idle;
              if (two_idle) begin
                st_r  <= FXP_HUNT; // R18
                mii_r <= '0; // R9
              end else begin
                mii_r.er <= 1'b1; // R7
                mii_r.d  <= `FXP_NIB_BAD; // R7
                stb_r    <= 1'b1;
              end
            end
          end
          default: begin
            st_r  <= FXP_HUNT;
            mii_r <= '0;
          end
        endcase
      end
    end
  end

endmodule : fxp_rx_pcs

`default_nettype wire

// ### logic/fxp_regs.svh
// Constants for the fiber-capable receive coding block
`ifndef FXP_REGS_SVH
`define FXP_REGS_SVH

// Code-groups, first received bit in the MSB
`define FXP_CG_IDLE   5'h1F
`define FXP_CG_T      5'h0D
`define FXP_CG_R      5'h07
`define FXP_JK_PAIR   10'h311
`define FXP_JK_TAIL   3'h6

// Nibbles toward the MAC
`define FXP_NIB_PRE   4'h5
`define FXP_NIB_BAD   4'hE
`define FXP_NIB_ZERO  4'h0

// Bit and cycle counts
`define FXP_SYM_LAST  3'h4
`define FXP_IDLE2_RUN 4'hA
`define FXP_FEF_ONES  7'h54
`define FXP_FEF_LONG  7'h55
`define FXP_FEF_REPS  2'h3

// Link-up qualification time
`define FXP_CLK_NS    50
`define FXP_LINK_NS   395000
`define FXP_LINK_CYC  ((`FXP_LINK_NS + `FXP_CLK_NS - 1) / `FXP_CLK_NS)

`endif

// ### logic/fxp_pkg.sv
// Types shared by the fiber-capable receive coding block
`default_nettype none

package fxp_pkg;

  // Aligner states, Gray coded along hunt -> check -> data
  typedef enum logic [1:0] {
    FXP_HUNT = 2'b00,
    FXP_SSD  = 2'b01,
    FXP_DATA = 2'b11,
    FXP_BAD  = 2'b10
  } fxp_aln_e;

  // Receive nibble interface toward the MAC
  typedef struct packed {
    logic       crs;
    logic       dv;
    logic       er;
    logic [3:0] d;
  } fxp_mii_s;

  // Decoded code-group
  typedef struct packed {
    logic       err;
    logic [3:0] nib;
  } fxp_dec_s;

endpackage : fxp_pkg

`default_nettype wire

// ### logic/fxp_fef_gen.sv
// Far-end fault pattern generator
`include "fxp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module fxp_fef_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Request
  input  wire logic req,
  // Pattern
  output logic      active,
  output logic      bit_out
);

  logic       act_r;
  logic [6:0] pos_r;
  logic [1:0] reps_r;

  wire cyc_end  = (pos_r == `FXP_FEF_ONES);
  wire last_rep = (reps_r == (`FXP_FEF_REPS - 2'h1));
  wire stop     = cyc_end & ~req & last_rep;

  assign active  = act_r;
  assign bit_out = act_r & ~cyc_end;

  always_ff @(posedge clk) begin
    if (rst) begin
      act_r  <= 1'b0;
      pos_r  <= 7'h00;
      reps_r <= 2'h0;
    end else if (ce) begin
      if (!act_r) begin
        act_r  <= req;
        pos_r  <= 7'h00;
        reps_r <= 2'h0;
      end else if (cyc_end) begin
        act_r <= ~stop;
        pos_r <= 7'h00;
        if (!last_rep && reps_r != `FXP_FEF_REPS) begin
          reps_r <= reps_r + 2'h1;
        end
      end else begin
        pos_r <= pos_r + 7'h01;
      end
    end
  end

endmodule : fxp_fef_gen

`default_nettype wire

// ### logic/fxp_fef_det.sv
// Far-end fault pattern detector
`include "fxp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module fxp_fef_det (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Stream
  input  wire logic en,
  input  wire logic bit_in,
  // Result
  output logic      found
);

  logic [6:0] run_r;
  logic [1:0] hits_r;
  logic       found_r;

  wire run_full  = (run_r == `FXP_FEF_ONES);
  wire run_long  = (run_r == `FXP_FEF_LONG);
  wire good_zero = ~bit_in & run_full;

  assign found = found_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      run_r   <= 7'h00;
      hits_r  <= 2'h0;
      found_r <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        run_r   <= 7'h00;
        hits_r  <= 2'h0;
        found_r <= 1'b0;
      end else if (bit_in) begin
        if (!run_long) begin
          run_r <= run_r + 7'h01;
        end
        if (run_full) begin
          hits_r  <= 2'h0;
          found_r <= 1'b0;
        end
      end else begin
        run_r <= 7'h00;
        if (good_zero) begin
          if (hits_r != `FXP_FEF_REPS) begin
            hits_r <= hits_r + 2'h1;
          end
          if (hits_r >= (`FXP_FEF_REPS - 2'h1)) begin
            found_r <= 1'b1;
          end
        end else begin
          hits_r  <= 2'h0;
          found_r <= 1'b0;
        end
      end
    end
  end

endmodule : fxp_fef_det

`default_nettype wire

// ### sim/fxp_peer.sv
// Line-side model of the remote peer feeding the receive path
`timescale 1ns/1ps
`default_nettype none

module fxp_peer (
  // Clock
  input  wire logic clk,
  // Line
  output logic      line_nrzi,
  output logic      descr_bit
);
  logic q[$];
  logic nrz;

  initial begin
    line_nrzi = 1'b0;
    descr_bit = 1'b1;
  end

  // One bit per clock, idle fill between frames
  always @(posedge clk) begin
    nrz = (q.size() != 0) ? q.pop_front() : 1'b1;
    descr_bit <= nrz;
    if (nrz) begin
      line_nrzi <= ~line_nrzi;
    end
  end

  task ones(input int n);
    repeat (n) q.push_back(1'b1);
  endtask : ones

  task put(input logic b);
    q.push_back(b);
  endtask : put

  task sym(input logic [4:0] v);
    for (int i = 4; i >= 0; i--) q.push_back(v[i]);
  endtask : sym
endmodule : fxp_peer

`default_nettype wire

// ### sim/fxp_rx_pcs_sva.sv
// Port assertions for the receive coding block
`timescale 1ns/1ps
`default_nettype none

module fxp_rx_pcs_chk
  import fxp_pkg::*;
#(
  parameter int LINK_CYC = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Watched ports
  input wire logic        sig_det,
  input wire logic        tx_line_nrzi,
  input wire logic        tx_mlt3_en,
  input wire logic        fiber_mode,
  input wire logic        link_up,
  input wire logic        fef_seen,
  input wire logic [15:0] false_carrier_cnt,
  input wire fxp_mii_s    mii_rx,
  input wire logic        rx_nib_stb
);
  logic [15:0] sd_run_r;
  logic [15:0] sd_run_nxt;

  // Consecutive signal detect samples, saturating
  assign sd_run_nxt = !sig_det ? 16'h0000 : (&sd_run_r ? sd_run_r : sd_run_r + 16'h0001);

  always_ff @(posedge clk) begin
    if (rst) begin
      sd_run_r <= 16'h0000;
    end else begin
      sd_run_r <= sd_run_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_mlt3_sel; tx_mlt3_en == !fiber_mode; endproperty
  a_mlt3_sel: assert property (p_mlt3_sel)
    else $error("mode and line coding disagree");
  property p_fc_step;
    $changed(false_carrier_cnt) |-> false_carrier_cnt == $past(false_carrier_cnt) + 16'h0001
      && rx_nib_stb && mii_rx.er && mii_rx.d == 4'hE;
  endproperty
  a_fc_step: assert property (p_fc_step)
    else $error("false carrier step wrong");
  property p_link_rise; $rose(link_up) |-> $past(sd_run_r) >= LINK_CYC; endproperty
  a_link_rise: assert property (p_link_rise)
    else $error("link up too early");
  property p_link_fall; !sig_det |-> ##2 !link_up; endproperty
  a_link_fall: assert property (p_link_fall)
    else $error("link stayed up without signal");
  property p_fef_down; fef_seen |-> !link_up && fiber_mode; endproperty
  a_fef_down: assert property (p_fef_down)
    else $error("far fault without link down");
  property p_fef_idle; fef_seen [*2] |-> tx_line_nrzi != $past(tx_line_nrzi); endproperty
  a_fef_idle: assert property (p_fef_idle)
    else $error("non idle sent during far fault");
  property p_stb_gap; rx_nib_stb |=> !rx_nib_stb [*4]; endproperty
  a_stb_gap: assert property (p_stb_gap)
    else $error("nibble strobes closer than a symbol");
  property p_preamble;
    $rose(mii_rx.dv) |-> (rx_nib_stb && mii_rx.d == 4'h5) ##5 (rx_nib_stb && mii_rx.d == 4'h5);
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble pair wrong");
  property p_bad_nib; mii_rx.er && !mii_rx.dv |-> mii_rx.d == 4'hE && mii_rx.crs; endproperty
  a_bad_nib: assert property (p_bad_nib)
    else $error("bad start nibble wrong");

  c_pkt: cover property ($rose(mii_rx.dv));
  c_bad: cover property ($changed(false_carrier_cnt));
  c_fef: cover property ($rose(fef_seen));
endmodule : fxp_rx_pcs_chk

bind fxp_rx_pcs fxp_rx_pcs_chk #(.LINK_CYC(LINK_CYC)) fxp_rx_pcs_chk_i (
  .clk(clk), .rst(rst), .sig_det(sig_det), .tx_line_nrzi(tx_line_nrzi),
  .tx_mlt3_en(tx_mlt3_en), .fiber_mode(fiber_mode), .link_up(link_up), .fef_seen(fef_seen),
  .false_carrier_cnt(false_carrier_cnt), .mii_rx(mii_rx), .rx_nib_stb(rx_nib_stb)
);

`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the receive coding block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import fxp_pkg::*;
  localparam int LINK_CYC = 20;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic clk, rst, ce, fx_strap, fx_cfg_we, fx_cfg_val, sig_det, tx_nrz_bit, tx_scr_bit;
  logic rx_line_nrzi, rx_descr_bit, tx_line_nrzi, tx_mlt3_en, fiber_mode, link_up, fef_seen;
  logic [15:0] false_carrier_cnt;
  fxp_mii_s    mii_rx;
  logic        rx_nib_stb;
  fxp_mii_s    got[$];
  logic        txq[$];
  logic        tx_prev = 1'b0;
  int          cyc = 0;
  int          err_total = 0;
  int          checks = 0;

  fxp_rx_pcs #(.LINK_CYC(LINK_CYC)) fxp_rx_pcs_i (
    .clk(clk), .rst(rst), .ce(ce), .fx_strap(fx_strap), .fx_cfg_we(fx_cfg_we),
    .fx_cfg_val(fx_cfg_val), .sig_det(sig_det), .rx_line_nrzi(rx_line_nrzi),
    .rx_descr_bit(rx_descr_bit), .tx_nrz_bit(tx_nrz_bit), .tx_scr_bit(tx_scr_bit),
    .tx_line_nrzi(tx_line_nrzi), .tx_mlt3_en(tx_mlt3_en), .fiber_mode(fiber_mode),
    .link_up(link_up), .fef_seen(fef_seen), .false_carrier_cnt(false_carrier_cnt),
    .mii_rx(mii_rx), .rx_nib_stb(rx_nib_stb)
  );
  fxp_peer fxp_peer_i (.clk(clk), .line_nrzi(rx_line_nrzi), .descr_bit(rx_descr_bit));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Strobe capture, transmit line decode and hang guard
  always @(posedge clk) begin
    cyc++;
    if (rx_nib_stb === 1'b1) got.push_back(mii_rx);
    txq.push_back(tx_line_nrzi ^ tx_prev);
    tx_prev = tx_line_nrzi;
    if (cyc == 20000) begin
      err_total++;
      $display("mismatch timeout expected end seen running");
      finish_test();
    end
  end

  task chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
  endtask : do_reset

  task drain;
    int n;
    n = 0;
    while (fxp_peer_i.q.size() != 0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    repeat (12) @(negedge clk);
  endtask : drain

  task cfg(input logic v);
    @(posedge clk);
    fx_cfg_we <= 1'b1;
    fx_cfg_val <= v;
    @(posedge clk);
    fx_cfg_we <= 1'b0;
    @(negedge clk);
  endtask : cfg

  task t_link;
    int n;
    @(posedge clk);
    sig_det <= 1'b0;
    repeat (3) @(posedge clk);
    sig_det <= 1'b1;
    n = 0;
    while (link_up !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("link delay", LINK_CYC + 2, n);
    $display("test link done");
  endtask : t_link

  task t_pkt(input int n, input logic tr);
    got.delete();
    fxp_peer_i.ones(10);
    fxp_peer_i.sym(5'h18);
    fxp_peer_i.sym(5'h11);
    for (int i = 0; i < n; i++) fxp_peer_i.sym(ENC[i]);
    fxp_peer_i.sym(tr ? 5'h0D : 5'h1F);
    fxp_peer_i.sym(tr ? 5'h07 : 5'h1F);
    drain();
    chk("nibble count", n + 2, got.size());
    foreach (got[i]) chk("nibble", i < 2 ? 7'h65 : {3'b110, 4'(i - 2)}, got[i]);
    chk("end of stream", 0, mii_rx);
    $display("test packet done");
  endtask : t_pkt

  task t_bad;
    logic [15:0] c0;
    c0 = false_carrier_cnt;
    got.delete();
    fxp_peer_i.ones(10);
    fxp_peer_i.sym(5'h14);
    fxp_peer_i.sym(5'h15);
    fxp_peer_i.sym(5'h1F);
    fxp_peer_i.sym(5'h1F);
    drain();
    chk("false carrier", c0 + 16'h0001, false_carrier_cnt);
    chk("bad nibble seen", 1, got.size() != 0);
    foreach (got[i]) chk("bad nibble", 7'h5E, got[i]);
    chk("bad end", 0, mii_rx);
    $display("test bad start done");
  endtask : t_bad

  // Clock enable low must hold the line encoder still
  task t_freeze;
    logic acc;
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(negedge clk);
    txq.delete();
    repeat (8) @(posedge clk);
    ce <= 1'b1;
    acc = 1'b0;
    foreach (txq[i]) acc |= txq[i];
    chk("frozen line", 0, acc);
    repeat (3) @(negedge clk);
    txq.delete();
    repeat (4) @(negedge clk);
    acc = 1'b1;
    foreach (txq[i]) acc &= txq[i];
    chk("line resumed", 1, acc);
    chk("frozen link", 1, link_up);
    $display("test freeze done");
  endtask : t_freeze

  task t_fiber;
    int run, nrun;
    logic seen, acc;
    @(posedge clk);
    sig_det <= 1'b0;
    fx_strap <= 1'b1;
    do_reset();
    chk("strap fiber", 1, fiber_mode);
    cfg(1'b0);
    chk("cfg copper", 1, tx_mlt3_en);
    cfg(1'b1);
    chk("cfg fiber", 0, tx_mlt3_en);
    txq.delete();
    repeat (400) @(negedge clk);
    run = 0;
    nrun = 0;
    seen = 1'b0;
    foreach (txq[i]) begin
      if (txq[i]) begin
        run++;
      end else begin
        if (seen && nrun < 3) chk("fault ones", 84, run);
        if (seen && nrun < 3) nrun++;
        seen = 1'b1;
        run = 0;
      end
    end
    chk("fault cycles", 3, nrun);
    t_link();
    repeat (100) @(negedge clk);
    txq.delete();
    repeat (20) @(negedge clk);
    acc = 1'b0;
    foreach (txq[i]) acc |= txq[i];
    chk("fiber tx source", 0, acc);
    @(posedge clk);
    tx_nrz_bit <= 1'b1;
    tx_scr_bit <= 1'b0;
    repeat (3) @(negedge clk);
    txq.delete();
    repeat (20) @(negedge clk);
    acc = 1'b1;
    foreach (txq[i]) acc &= txq[i];
    chk("fiber tx ones", 1, acc);
    $display("test fiber done");
  endtask : t_fiber

  task t_fef;
    int n;
    logic acc;
    fxp_peer_i.put(1'b0);
    for (int r = 0; r < 3; r++) begin
      fxp_peer_i.ones(r == 2 ? 83 : 84);
      fxp_peer_i.put(1'b0);
    end
    drain();
    chk("fault short run", 0, fef_seen);
    fxp_peer_i.put(1'b0);
    for (int r = 0; r < 6; r++) begin
      fxp_peer_i.ones(84);
      fxp_peer_i.put(1'b0);
    end
    n = 0;
    while (fef_seen !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    chk("fault seen", 1, fef_seen);
    chk("fault link", 0, link_up);
    txq.delete();
    repeat (20) @(negedge clk);
    acc = 1'b1;
    foreach (txq[i]) acc &= txq[i];
    chk("fault idles", 1, acc);
    drain();
    $display("test far fault done");
  endtask : t_fef

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    fx_strap = 1'b0;
    fx_cfg_we = 1'b0;
    fx_cfg_val = 1'b0;
    sig_det = 1'b0;
    tx_nrz_bit = 1'b0;
    tx_scr_bit = 1'b1;
    do_reset();
    t_link();
    t_link();
    t_pkt(16, 1'b1);
    t_pkt(2, 1'b0);
    t_bad();
    t_bad();
    t_freeze();
    t_fiber();
    t_pkt(3, 1'b1);
    t_fef();
    finish_test();
  end
endmodule : testbench

`default_nettype wire
